// file: verilog/wsg_top.sv
// Set-point generator, periodic except the one-shot step, with its APB parameter registers.
`timescale 1ns/1ps
module wsg_top #(
	parameter int unsigned MS_CYCLES_P = wsg_pkg::MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [wsg_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	output logic signed [31:0] setpoint_o,
	output logic setpoint_valid_o
);
	localparam int unsigned TW = wsg_pkg::TIME_W;
	localparam int unsigned FW = wsg_pkg::FRAC_W;

	logic [wsg_pkg::IDX_W-1:0] idx;
	logic aligned, acc, fire, is_ctrl, is_stat, ok, wr_en;
	logic [4:0] wdec, rdec;
	logic [31:0] bank_rd, ctrl_word, stat_word;
	logic [wsg_pkg::NPAR*32-1:0] bank_all;
	logic [31:0] pw [wsg_pkg::NPAR];
	logic [1:0] shape, src;
	logic active, mismatch, tick, kick;
	wsg_pkg::wsg_state_t st;
	logic [TW-1:0] t, seg_len, den;
	logic [31:0] ms_cnt;
	logic [TW:0] rem, r2;
	logic [4:0] div_cnt;
	logic [FW-1:0] quo, frac;
	logic qbit;
	logic signed [31:0] next_sp;

	// Float to integer, truncating toward zero and saturating
	function automatic logic signed [31:0] f2i(input logic [31:0] f);
		logic [54:0] m;
		logic [31:0] mag;
		m = {31'h0, 1'b1, f[22:0]};
		mag = 32'h0;
		if (f[30:23] > 8'd157) begin
			mag = 32'h7fff_ffff;
		end else if (f[30:23] >= 8'd127) begin
			m = m << (f[30:23] - 8'd127);
			mag = {1'b0, m[53:23]};
		end
		return f[31] ? -$signed(mag) : $signed(mag);
	endfunction

	// Float milliseconds to a whole count, never below one
	function automatic logic [TW-1:0] to_ms(input logic [31:0] f);
		logic signed [31:0] v;
		v = f2i(f);
		if (v <= 0) begin
			return TW'(1);
		end else if (v > 32'sh00ff_ffff) begin
			return '1;
		end
		return v[TW-1:0];
	endfunction

	// Index to parameter slot: {hit, slot}; get selects the read index
	function automatic logic [4:0] find_par(input logic [11:0] i,
		input logic get);
		logic [4:0] r;
		r = 5'h0;
		for (int k = 0; k < int'(wsg_pkg::NPAR); k++) begin
			if (i == (get ? wsg_pkg::GET_IDX[k] : wsg_pkg::SET_IDX[k])) begin
				r = {1'b1, 4'(k)};
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] shape_of(input wsg_pkg::wsg_state_t s);
		case (s)
			wsg_pkg::ST_SQ_LO, wsg_pkg::ST_SQ_HI: return wsg_pkg::SHAPE_SQUARE;
			wsg_pkg::ST_STEP_LO, wsg_pkg::ST_STEP_HI: return wsg_pkg::SHAPE_STEP;
			wsg_pkg::ST_RAMP_UP, wsg_pkg::ST_RAMP_DN: return wsg_pkg::SHAPE_RAMP;
			default: return wsg_pkg::SHAPE_SINE;
		endcase
	endfunction

	// APB decode; printed offsets are word indices
	assign idx = paddr_i[wsg_pkg::ADDR_W-1:2];
	assign aligned = (paddr_i[1:0] == 2'h0);
	assign acc = psel_i & penable_i;
	assign fire = acc & pready_o;
	assign wdec = find_par(idx, 1'b0);
	assign rdec = find_par(idx, 1'b1);
	assign is_ctrl = aligned && idx == wsg_pkg::CTRL_IDX;
	assign is_stat = aligned && idx == wsg_pkg::STAT_IDX;
	assign ok = pwrite_i ? (aligned & wdec[4]) | is_ctrl
		: (aligned & rdec[4]) | is_ctrl | is_stat;
	// A parameter lands only at its set index, at the completing edge
	assign wr_en = fire & pwrite_i & aligned & wdec[4];

	wsg_param_bank #(
		.W(32),
		.N(wsg_pkg::NPAR),
		.AW(wsg_pkg::PAR_AW)
	) u_bank (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.wr_en_i(wr_en),
		.wr_addr_i(wdec[3:0]),
		.wr_data_i(pwdata_i),
		.rd_addr_i(rdec[3:0]),
		.rd_data_o(bank_rd),
		.all_o(bank_all)
	);

	// Flat bank view, one word per parameter
	generate
		for (genvar i = 0; i < int'(wsg_pkg::NPAR); i++) begin : g_pw
			assign pw[i] = bank_all[i*32 +: 32];
		end
	endgenerate

	assign ctrl_word = {22'h0, src, 6'h0, shape};
	assign stat_word = {30'h0,
		st == wsg_pkg::ST_SQ_HI || st == wsg_pkg::ST_STEP_HI
			|| st == wsg_pkg::ST_RAMP_UP,
		st != wsg_pkg::ST_IDLE};

	// One wait state: bank read data is registered in the first access cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end else if (acc && !pready_o) begin
			pready_o <= 1'b1;
			pslverr_o <= !ok;
			if (pwrite_i || !ok) begin
				prdata_o <= 32'h0;
			end else if (rdec[4]) begin
				prdata_o <= bank_rd;
			end else if (is_ctrl) begin
				prdata_o <= ctrl_word;
			end else begin
				prdata_o <= stat_word;
			end
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// Shape and source selection; source comes up local
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shape <= wsg_pkg::SHAPE_RESET;
			src <= wsg_pkg::SRC_LOCAL;
		end else if (fire && pwrite_i && is_ctrl) begin
			shape <= pwdata_i[wsg_pkg::CTRL_SHAPE_LSB +: 2];
			src <= pwdata_i[wsg_pkg::CTRL_SRC_LSB +: 2];
		end
	end

	// Only code one hands the output to the generator
	assign active = (src == wsg_pkg::SRC_FGEN);
	assign mismatch = active ? (st == wsg_pkg::ST_IDLE
		|| shape_of(st) != shape) : (st != wsg_pkg::ST_IDLE);

	// Length of the present segment in milliseconds
	always_comb begin
		case (st)
			wsg_pkg::ST_SINE: seg_len = to_ms(pw[wsg_pkg::P_SINE_PRD]);
			wsg_pkg::ST_SQ_LO: seg_len = to_ms(pw[wsg_pkg::P_SQ_LO_DW]);
			wsg_pkg::ST_SQ_HI: seg_len = to_ms(pw[wsg_pkg::P_SQ_HI_DW]);
			wsg_pkg::ST_RAMP_UP: seg_len = to_ms(pw[wsg_pkg::P_RAMP_RISE]);
			wsg_pkg::ST_RAMP_DN: seg_len = to_ms(pw[wsg_pkg::P_RAMP_FALL]);
			default: seg_len = TW'(1);
		endcase
	end

	// Millisecond strobe, realigned whenever the waveform restarts
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ms_cnt <= 32'h0;
			tick <= 1'b0;
		end else if (mismatch || ms_cnt == 32'(MS_CYCLES_P - 1)) begin
			ms_cnt <= 32'h0;
			tick <= !mismatch;
		end else begin
			ms_cnt <= ms_cnt + 32'h1;
			tick <= 1'b0;
		end
	end

	// Segment sequencer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= wsg_pkg::ST_IDLE;
			t <= '0;
		end else if (mismatch) begin
			t <= '0;
			if (!active) begin
				st <= wsg_pkg::ST_IDLE;
			end else begin
				case (shape)
					wsg_pkg::SHAPE_SINE: st <= wsg_pkg::ST_SINE;
					wsg_pkg::SHAPE_SQUARE: st <= wsg_pkg::ST_SQ_LO;
					wsg_pkg::SHAPE_STEP: st <= wsg_pkg::ST_STEP_LO;
					default: st <= wsg_pkg::ST_RAMP_UP;
				endcase
			end
		end else if (tick && st != wsg_pkg::ST_STEP_HI) begin
			if ({1'b0, t} + 25'h1 >= {1'b0, seg_len}) begin
				t <= '0;
				case (st)
					wsg_pkg::ST_SQ_LO: st <= wsg_pkg::ST_SQ_HI;
					wsg_pkg::ST_SQ_HI: st <= wsg_pkg::ST_SQ_LO;
					wsg_pkg::ST_STEP_LO: st <= wsg_pkg::ST_STEP_HI;
					wsg_pkg::ST_RAMP_UP: st <= wsg_pkg::ST_RAMP_DN;
					wsg_pkg::ST_RAMP_DN: st <= wsg_pkg::ST_RAMP_UP;
					default: st <= st;
				endcase
			end else begin
				t <= t + TW'(1);
			end
		end
	end

	// Serial divider gives the elapsed fraction t/len; avoids a wide divider
	assign r2 = {rem[TW-1:0], 1'b0};
	assign qbit = (r2 >= {1'b0, den});
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			kick <= 1'b0;
			div_cnt <= 5'h0;
			rem <= '0;
			den <= TW'(1);
			quo <= '0;
			frac <= '0;
		end else begin
			kick <= mismatch | tick;
			if (kick) begin
				rem <= {1'b0, t};
				den <= seg_len;
				quo <= '0;
				div_cnt <= 5'(FW);
				if (t == '0) begin
					frac <= '0;
				end
			end else if (div_cnt != 5'h0) begin
				rem <= qbit ? r2 - {1'b0, den} : r2;
				quo <= {quo[FW-2:0], qbit};
				div_cnt <= div_cnt - 5'h1;
				if (div_cnt == 5'h1) begin
					frac <= {quo[FW-2:0], qbit};
				end
			end
			// A new segment starts at phase zero, not at the old phase
			if (mismatch || (tick && st != wsg_pkg::ST_STEP_HI
				&& {1'b0, t} + 25'h1 >= {1'b0, seg_len})) begin
				frac <= '0;
			end
		end
	end

	// Output value for the present segment
	always_comb begin
		logic signed [32:0] diff;
		logic signed [49:0] prod;
		logic signed [16:0] sn;
		logic signed [48:0] sprod;
		logic [3:0] k;
		logic [15:0] lut;
		lut = 16'h0000;
		diff = 33'(f2i(pw[wsg_pkg::P_RAMP_HI]))
			- 33'(f2i(pw[wsg_pkg::P_RAMP_LO]));
		prod = diff * $signed({1'b0, frac});
		// Bit 15 gives the sign, bit 14 mirrors; the peak is exactly one
		k = frac[14] ? 4'hf - frac[13:10] + 4'h1 : frac[13:10];
		case (k)
			4'h0: lut = (frac[14] && frac[13:10] == 4'h0) ? 16'h8000 : 16'h0000;
			4'h1: lut = 16'h0c8c;
			4'h2: lut = 16'h18f9;
			4'h3: lut = 16'h2528;
			4'h4: lut = 16'h30fb;
			4'h5: lut = 16'h3c56;
			4'h6: lut = 16'h471c;
			4'h7: lut = 16'h5133;
			4'h8: lut = 16'h5a82;
			4'h9: lut = 16'h62f1;
			4'ha: lut = 16'h6a6d;
			4'hb: lut = 16'h70e2;
			4'hc: lut = 16'h7641;
			4'hd: lut = 16'h7a7c;
			4'he: lut = 16'h7d89;
			default: lut = 16'h7f61;
		endcase
		sn = frac[15] ? -$signed({1'b0, lut}) : $signed({1'b0, lut});
		sprod = f2i(pw[wsg_pkg::P_SINE_AMPL]) * sn;
		case (st)
			wsg_pkg::ST_SINE: next_sp = f2i(pw[wsg_pkg::P_SINE_OFF])
				+ sprod[46:15];
			wsg_pkg::ST_SQ_LO: next_sp = f2i(pw[wsg_pkg::P_SQ_LO]);
			wsg_pkg::ST_SQ_HI: next_sp = f2i(pw[wsg_pkg::P_SQ_HI]);
			wsg_pkg::ST_STEP_LO: next_sp = f2i(pw[wsg_pkg::P_STEP_LO]);
			wsg_pkg::ST_STEP_HI: next_sp = f2i(pw[wsg_pkg::P_STEP_HI]);
			wsg_pkg::ST_RAMP_UP: next_sp = f2i(pw[wsg_pkg::P_RAMP_LO])
				+ prod[47:16];
			wsg_pkg::ST_RAMP_DN: next_sp = f2i(pw[wsg_pkg::P_RAMP_HI])
				- prod[47:16];
			default: next_sp = 32'sh0;
		endcase
	end

	// Registered set point; zero and invalid while not selected
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			setpoint_o <= 32'sh0;
			setpoint_valid_o <= 1'b0;
		end else begin
			setpoint_o <= next_sp;
			setpoint_valid_o <= (st != wsg_pkg::ST_IDLE);
		end
	end

	// Helper registers and decoded levels for the checks below
	logic [3:0] h_wp, h_rp;
	logic [31:0] h_wd;
	logic signed [31:0] sq_hi_i, off_i, rlo_i;
	assign sq_hi_i = f2i(pw[wsg_pkg::P_SQ_HI]);
	assign off_i = f2i(pw[wsg_pkg::P_SINE_OFF]);
	assign rlo_i = f2i(pw[wsg_pkg::P_RAMP_LO]);
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			h_wp <= 4'h0;
			h_rp <= 4'h0;
			h_wd <= 32'h0;
		end else begin
			h_wp <= wdec[3:0];
			h_rp <= rdec[3:0];
			h_wd <= pwdata_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_sq_hi;
		(st == wsg_pkg::ST_SQ_HI)[*2];
	endsequence
	sequence s_sine_zero;
		(st == wsg_pkg::ST_SINE && frac == '0)[*2];
	endsequence
	sequence s_ramp_start;
		(st == wsg_pkg::ST_RAMP_UP && frac == '0)[*2];
	endsequence

	a_set_stores: assert property (wr_en |=> pw[h_wp] == h_wd)
		else $error("set write not stored");
	a_get_returns: assert property (acc && !pready_o && !pwrite_i && aligned
		&& rdec[4] |=> pready_o && prdata_o == pw[h_rp])
		else $error("get read returned wrong word");
	a_apb_wait: assert property (acc && !pready_o |=> pready_o ##1
		!pready_o)
		else $error("apb answer timing wrong");
	a_source_gate: assert property ((!active)[*3] |-> !setpoint_valid_o
		&& setpoint_o == 32'sh0)
		else $error("output driven while not selected");
	a_source_reset: assert property (!$past(rstn_i) |->
		src == wsg_pkg::SRC_LOCAL)
		else $error("source not local after reset");
	a_shape_step: assert property (active && mismatch
		&& shape == wsg_pkg::SHAPE_STEP |=> st == wsg_pkg::ST_STEP_LO)
		else $error("step shape not decoded");
	a_square_high: assert property (s_sq_hi ##0 $stable(sq_hi_i) |->
		setpoint_o == sq_hi_i)
		else $error("square high level wrong");
	a_square_dwell: assert property (tick && !mismatch
		&& st == wsg_pkg::ST_SQ_LO && {1'b0, t} + 25'h1 >= {1'b0, seg_len}
		|=> st == wsg_pkg::ST_SQ_HI && t == '0)
		else $error("square low dwell not ended");
	a_step_hold: assert property (st == wsg_pkg::ST_STEP_HI && !mismatch
		|=> st == wsg_pkg::ST_STEP_HI)
		else $error("step left high level");
	a_sine_offset: assert property (s_sine_zero ##0 $stable(off_i) |->
		setpoint_o == off_i)
		else $error("sine start not at offset");
	a_ramp_start: assert property (s_ramp_start ##0 $stable(rlo_i) |->
		setpoint_o == rlo_i)
		else $error("ramp does not start low");
endmodule

// file: inc/wsg_pkg.sv
// Constants, register map and types shared by the set-point generator.
package wsg_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 14;
	localparam int unsigned IDX_W = 12;
	localparam int unsigned TIME_W = 24;
	localparam int unsigned FRAC_W = 16;
	localparam int unsigned NPAR = 13;
	localparam int unsigned PAR_AW = 4;
	// Parameter slots in the bank
	localparam int unsigned P_SINE_AMPL = 0;
	localparam int unsigned P_SINE_OFF = 1;
	localparam int unsigned P_SINE_PRD = 2;
	localparam int unsigned P_SQ_LO = 3;
	localparam int unsigned P_SQ_HI = 4;
	localparam int unsigned P_SQ_LO_DW = 5;
	localparam int unsigned P_SQ_HI_DW = 6;
	localparam int unsigned P_STEP_LO = 7;
	localparam int unsigned P_STEP_HI = 8;
	localparam int unsigned P_RAMP_LO = 9;
	localparam int unsigned P_RAMP_HI = 10;
	localparam int unsigned P_RAMP_RISE = 11;
	localparam int unsigned P_RAMP_FALL = 12;
	// Register indices; byte address is four times the index
	localparam logic [11:0] SET_IDX [NPAR] = '{12'h603, 12'h605, 12'h607,
		12'h609, 12'h60b, 12'h60d, 12'h60f, 12'h611, 12'h613, 12'h615,
		12'h617, 12'h619, 12'h61b};
	localparam logic [11:0] GET_IDX [NPAR] = '{12'h604, 12'h606, 12'h608,
		12'h60a, 12'h60c, 12'h60e, 12'h610, 12'h612, 12'h614, 12'h616,
		12'h618, 12'h61a, 12'h61c};
	localparam logic [11:0] CTRL_IDX = 12'h620;
	localparam logic [11:0] STAT_IDX = 12'h621;
	// Control and status fields
	localparam int unsigned CTRL_SHAPE_LSB = 0;
	localparam int unsigned CTRL_SRC_LSB = 8;
	localparam int unsigned STAT_ACTIVE_BIT = 0;
	localparam int unsigned STAT_HIGH_BIT = 1;
	localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
	localparam logic [1:0] SHAPE_RESET = 2'h0;
	localparam logic [1:0] SHAPE_SINE = 2'h0;
	localparam logic [1:0] SHAPE_SQUARE = 2'h1;
	localparam logic [1:0] SHAPE_STEP = 2'h2;
	localparam logic [1:0] SHAPE_RAMP = 2'h3;
	localparam logic [1:0] SRC_LOCAL = 2'h0;
	localparam logic [1:0] SRC_FGEN = 2'h1;
	typedef enum {ST_IDLE, ST_SINE, ST_SQ_LO, ST_SQ_HI, ST_STEP_LO,
		ST_STEP_HI, ST_RAMP_UP, ST_RAMP_DN} wsg_state_t;
endpackage

// file: verilog/wsg_param_bank.sv
// Parameter bank: one write port, registered read port, flat view.
`timescale 1ns/1ps
module wsg_param_bank #(
	parameter int unsigned W = 32,
	parameter int unsigned N = 13,
	parameter int unsigned AW = 4
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [W-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [W-1:0] rd_data_o,
	output logic [N*W-1:0] all_o
);
	logic [W-1:0] mem [N];

	// One flop word per parameter, cleared at reset
	generate
		for (genvar i = 0; i < N; i++) begin : g_word
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					mem[i] <= wsg_pkg::PARAM_RESET;
				end else if (wr_en_i && wr_addr_i == AW'(i)) begin
					mem[i] <= wr_data_i;
				end
			end
			assign all_o[i*W +: W] = mem[i];
		end
	endgenerate

	// Read data always leaves from a register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= '0;
		end else if (rd_addr_i < AW'(N)) begin
			rd_data_o <= mem[rd_addr_i];
		end else begin
			rd_data_o <= '0;
		end
	end
endmodule

// file: tb/wsg_apb_host.sv
// APB master model standing in for the remote controller.
`timescale 1ns/1ps
module wsg_apb_host (
	input wire logic clk_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [wsg_pkg::ADDR_W-1:0] paddr_o,
	output logic [31:0] pwdata_o,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	input wire logic pslverr_i
);
	// Bus idle at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = '0;
		pwdata_o = 32'h0;
	end

	// One transfer of a whole 32-bit word
	task automatic xfer(input logic wr, input logic [11:0] idx,
		input logic [1:0] lsb, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= {idx, lsb};
		pwdata_o <= wd;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		rd = prdata_i;
		err = pslverr_i;
		// A lost answer must never look like a clean one
		if (n >= 64) begin
			err = 1'bx;
		end
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Scramble released data so nobody leans on a stale word
		pwdata_o <= ~wd;
	endtask
endmodule

// file: tb/tb_waveform_setpoint_generator.sv
// Self-checking bench for the set-point generator and its registers.
`timescale 1ns/1ps
module tb_waveform_setpoint_generator;
	// Short millisecond keeps the waveform runs brief
	localparam int unsigned MSC = 20;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, valid, err;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [31:0] setpoint;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;

	wsg_top #(.MS_CYCLES_P(MSC)) dut (.clk_i(clk), .rstn_i(rstn),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .setpoint_o(setpoint),
		.setpoint_valid_o(valid));
	wsg_apb_host host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
		.pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic report_and_stop();
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s %b not %b", $time, what, got, exp);
		end
	endtask

	// Sample one step after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic put(input logic [11:0] idx, input logic [31:0] d);
		host.xfer(1'b1, idx, 2'b00, d, rd, err);
		cmp_bit(err, 1'b0, "write error");
	endtask

	task automatic get(input logic [11:0] idx, input logic [31:0] d);
		host.xfer(1'b0, idx, 2'b00, 32'h0, rd, err);
		cmp_bit(err, 1'b0, "read error");
		cmp_word(rd, d, "read back");
	endtask

	// Write at the set slot, read back at the get slot
	task automatic chk_par(input int p, input logic [31:0] d);
		put(wsg_pkg::SET_IDX[p], d);
		get(wsg_pkg::GET_IDX[p], d);
	endtask

	task automatic refuse(input logic w, input logic [11:0] idx,
		input logic [1:0] lsb);
		host.xfer(w, idx, lsb, 32'h1234_5678, rd, err);
		cmp_bit(err, 1'b1, "refusal");
		if (!w) begin
			cmp_word(rd, 32'h0, "refused data");
		end
	endtask

	// Park on local source, start a shape, track its extremes
	task automatic shape_run(input logic [1:0] shape, input int span,
		input logic [31:0] v0, input logic [31:0] vmax,
		input logic [31:0] vmin, input int t_lo, input int t_hi);
		logic signed [31:0] mx, mn;
		int t_top;
		int n;
		put(wsg_pkg::CTRL_IDX, 32'h0);
		tick(4);
		cmp_bit(valid, 1'b0, "valid on local source");
		cmp_word(setpoint, 32'h0, "output on local source");
		put(wsg_pkg::CTRL_IDX, {22'h0, wsg_pkg::SRC_FGEN, 6'h0, shape});
		n = 0;
		while (valid !== 1'b1 && n < 6) begin
			tick(1);
			n++;
		end
		cmp_bit(valid, 1'b1, "valid rise");
		cmp_word(setpoint, v0, "first level");
		mx = setpoint;
		mn = setpoint;
		t_top = -1;
		for (n = 0; n < span; n++) begin
			tick(1);
			if (setpoint > mx) begin
				mx = setpoint;
			end
			if (setpoint < mn) begin
				mn = setpoint;
			end
			if (setpoint === vmax && t_top < 0) begin
				t_top = n;
			end
		end
		cmp_word(mx, vmax, "peak");
		cmp_word(mn, vmin, "trough");
		cmp_bit(t_top >= t_lo && t_top <= t_hi, 1'b1, "time to peak");
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		cmp_bit(valid, 1'b0, "valid after reset");
		get(wsg_pkg::CTRL_IDX, 32'h0);
		get(wsg_pkg::GET_IDX[3], wsg_pkg::PARAM_RESET);
		// Adjacent slots get different values, which exposes aliasing between neighbours
		chk_par(wsg_pkg::P_SINE_AMPL, 32'h4040_0000);
		chk_par(wsg_pkg::P_SINE_OFF, 32'h40b0_0000);
		chk_par(wsg_pkg::P_SINE_PRD, 32'h4080_0000);
		chk_par(wsg_pkg::P_SQ_LO, 32'h4040_0000);
		chk_par(wsg_pkg::P_SQ_HI, 32'h40e0_0000);
		chk_par(wsg_pkg::P_SQ_LO_DW, 32'h4000_0000);
		chk_par(wsg_pkg::P_SQ_HI_DW, 32'h3f80_0000);
		chk_par(wsg_pkg::P_STEP_LO, 32'hc000_0000);
		chk_par(wsg_pkg::P_STEP_HI, 32'h40a0_0000);
		chk_par(wsg_pkg::P_RAMP_LO, 32'h3f80_0000);
		chk_par(wsg_pkg::P_RAMP_HI, 32'h4120_0000);
		chk_par(wsg_pkg::P_RAMP_RISE, 32'h4080_0000);
		chk_par(wsg_pkg::P_RAMP_FALL, 32'h4000_0000);
		refuse(1'b0, wsg_pkg::SET_IDX[1], 2'b00);
		refuse(1'b1, wsg_pkg::GET_IDX[1], 2'b00);
		refuse(1'b0, 12'h7ff, 2'b00);
		refuse(1'b0, wsg_pkg::GET_IDX[1], 2'b01);
		get(wsg_pkg::GET_IDX[1], 32'h40b0_0000);
		// Square: 3 for 2 ms, 7 for 1 ms
		shape_run(wsg_pkg::SHAPE_SQUARE, 100, 32'h3, 32'h7, 32'h3, 30,
			44);
		// Step: -2 for 1 ms, then 5
		shape_run(wsg_pkg::SHAPE_STEP, 60, 32'hffff_fffe, 32'h5,
			32'hffff_fffe, 14, 24);
		// Ramp: 1 up to 10 over 4 ms, back over 2 ms
		shape_run(wsg_pkg::SHAPE_RAMP, 160, 32'h1, 32'ha, 32'h1, 55,
			120);
		// Sine: 5.5 + 3 sin, 4 ms period, truncated to 8 and 2
		shape_run(wsg_pkg::SHAPE_SINE, 120, 32'h5, 32'h8, 32'h2, 14,
			44);
		get(wsg_pkg::STAT_IDX, 32'h1);
		// Source code 2 is not the generator: output stops
		put(wsg_pkg::CTRL_IDX, 32'h0000_0201);
		tick(3);
		cmp_bit(valid, 1'b0, "valid on idle source");
		cmp_word(setpoint, 32'h0, "output on idle source");
		get(wsg_pkg::CTRL_IDX, 32'h0000_0201);
		get(wsg_pkg::STAT_IDX, 32'h0);
		// Reset in mid-run clears the bank and parks the source on local
		put(wsg_pkg::CTRL_IDX, 32'h0000_0101);
		tick(4);
		cmp_bit(valid, 1'b1, "valid before reset");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		cmp_bit(valid, 1'b0, "valid after mid-run reset");
		get(wsg_pkg::CTRL_IDX, 32'h0);
		get(wsg_pkg::GET_IDX[1], wsg_pkg::PARAM_RESET);
		report_and_stop();
	end
endmodule
